// *** rtl/clk_status_pkg.sv ***
package clk_status_pkg;

    // ********************************************************************
    // Register offsets (byte addresses = 4 x index)
    // ********************************************************************
    localparam logic [7:0] IDX_MAIN_CLOCK_STATUS = 8'h03;
    localparam logic [7:0] IDX_FAST_OSC_CONTROL  = 8'h10;
    localparam logic [7:0] IDX_FAST_OSC_FREQ     = 8'h11;
    localparam logic [7:0] IDX_FAST_OSC_TEMP     = 8'h12;
    localparam logic [7:0] IDX_SLOW_OSC_CONTROL  = 8'h18;
    localparam logic [7:0] IDX_PROTECT_KEY       = 8'h20;

    // ********************************************************************
    // Field positions
    // ********************************************************************
    localparam int POS_EXT_STARTED   = 7;
    localparam int POS_SLOW_STABLE   = 5;
    localparam int POS_FAST_STABLE   = 4;
    localparam int POS_SWITCH_PEND   = 0;
    localparam int POS_KEEP_RUNNING  = 1;
    localparam int POS_CAL_LOCK      = 7;
    localparam int FREQ_TRIM_W       = 6;
    localparam int TEMP_TRIM_W       = 4;

    // ********************************************************************
    // Reset values, key and timing
    // ********************************************************************
    localparam logic [7:0] RST_CONTROL    = 8'h00;
    localparam logic [7:0] PROTECT_KEY    = 8'hD8;
    localparam int         UNLOCK_WINDOW  = 4;
    localparam int         GATE_OSC_CYC   = 4;
    localparam int         EXT_START_CYC  = 2;
    localparam logic [1:0] SRC_FAST       = 2'h0;
    localparam logic [1:0] SRC_SLOW       = 2'h1;
    localparam logic [1:0] SRC_EXT        = 2'h3;

    // Oscillator requests and status, grouped
    typedef struct packed {
        logic fastReq;
        logic slowReq;
        logic extReq;
    } osc_req_type;

    typedef struct packed {
        logic fastRunning;
        logic slowRunning;
        logic extEdge;
        logic fastTick;
        logic slowTick;
    } osc_in_type;

    typedef enum logic [2:0] {
        SW_IDLE = 3'b001,
        SW_WAIT = 3'b010,
        SW_DONE = 3'b100
    } switch_state_type;

endpackage

// *** rtl/main_clock_status_and_osc_trim.sv ***
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
// Summary of operation
// R1: Status bit 7 reads 0 until the external pin clock has started, then 1.
// R2: Status bit 5 shows the slow oscillator stable, only while it is requested.
// R3: Status bit 4 shows the fast oscillator stable, only while it is requested.
// R4: A kept-running but unrequested oscillator reads its stable bit as 0.
// R5: Status bit 0 is high while a source switch waits, cleared when the new source is stable.
// R6: Keep-running bit 1 holds the oscillator powered in every mode.
// R7: An oscillator's clock gate stays shut while nobody requests it.
// R8: With keep-running set the gate opens four oscillator cycles after a request.
// R9: Frequency trim bits 5:0 load the fuse-selected factory value on the first clock after reset release.
// R10: Temperature trim bits 3:0 load the fuse-selected factory value on the first clock after reset release.
// R11: While lock bit 7 is set, writes to both trim registers are ignored.
// R12: The lock bit is loaded from the oscillator lock fuse bit after reset.
// R13: Protected registers change only within four accesses after the key write.
// R14: The status register is read-only and its unused bits read zero.
module main_clock_status_and_osc_trim
    import clk_status_pkg::*;
#(
    parameter logic [5:0] FREQ_TRIM_16M = 6'h20,
    parameter logic [5:0] FREQ_TRIM_20M = 6'h20,
    parameter logic [3:0] TEMP_TRIM_16M = 4'h8,
    parameter logic [3:0] TEMP_TRIM_20M = 4'h8,
    parameter int         GATE_CYCLES   = GATE_OSC_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Avalon-MM slave
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    output logic [1:0]       response,
    // Fuses
    input  wire logic        frequencySelectFuse,
    input  wire logic        oscLockFuseBit,
    // Main clock source selection and requests
    input  wire logic [1:0]  mainSourceSel,
    input  wire osc_req_type periphReq,
    input  wire osc_in_type  oscIn,
    // Oscillator controls
    output logic             fastOscPowerOn,
    output logic             slowOscPowerOn,
    output logic             fastGateOpen,
    output logic             slowGateOpen,
    output logic [1:0]       activeSource,
    output logic [5:0]       fastOscFreqTrim,
    output logic [3:0]       fastOscTempSlopeTrim
);

    // ********************************************************************
    // Parameter check
    // ********************************************************************
    if (GATE_CYCLES < 1 || GATE_CYCLES > 15) begin : gen_bad_gate
        $error("GATE_CYCLES out of range");
    end

    function automatic logic srcStable(input logic [1:0] s, input logic f, input logic l, input logic e);
        srcStable = (s == SRC_FAST) ? f : (s == SRC_SLOW) ? l : (s == SRC_EXT) ? e : 1'b0;
    endfunction

    // ********************************************************************
    // Registers
    // ********************************************************************
    logic                   fastKeep_ff;
    logic                   slowKeep_ff;
    logic [5:0]             freqTrim_ff;
    logic [3:0]             tempTrim_ff;
    logic                   calLock_ff;
    logic                   fuseLoaded_ff;
    logic [2:0]             unlockCnt_ff;
    logic                   extStarted_ff;
    logic [1:0]             extEdges_ff;
    logic [3:0]             fastGateCnt_ff;
    logic [3:0]             slowGateCnt_ff;
    logic                   fastStable_ff;
    logic                   slowStable_ff;
    logic [1:0]             activeSrc_ff;
    switch_state_type       swState_ff;
    logic                   ackPending_ff;
    logic [31:0]            rdData_ff;
    logic [1:0]             resp_ff;

    logic fastReq;
    logic slowReq;
    logic extReq;
    logic access;
    logic done;
    logic wrEn;
    logic protOk;
    logic newStable;

    // Request from main clock selection, the active source or any peripheral
    assign fastReq  = periphReq.fastReq | (activeSrc_ff == SRC_FAST) | (mainSourceSel == SRC_FAST);
    assign slowReq  = periphReq.slowReq | (activeSrc_ff == SRC_SLOW) | (mainSourceSel == SRC_SLOW);
    assign extReq   = periphReq.extReq  | (activeSrc_ff == SRC_EXT)  | (mainSourceSel == SRC_EXT);
    // One wait cycle per access keeps read data on a flop
    assign access   = (read | write) & ~ackPending_ff;
    // Writes commit at the answer edge, where the master sees waitrequest low
    assign done     = (read | write) & ackPending_ff;
    assign wrEn     = write & done & byteenable[0];
    // R13: key window check
    assign protOk   = (unlockCnt_ff != 3'h0);
    assign newStable = srcStable(mainSourceSel, fastStable_ff, slowStable_ff, extStarted_ff);

    // Bus handshake: waitrequest high until the answer cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ackPending_ff <= 1'b0;
        end else begin
            ackPending_ff <= access;
        end
    end

    // R13: Unlock window opened by the key, counted down per access
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            unlockCnt_ff <= 3'h0;
        end else if (wrEn && address[7:2] == IDX_PROTECT_KEY[5:0] && writedata[7:0] == PROTECT_KEY) begin
            unlockCnt_ff <= 3'(UNLOCK_WINDOW);
        end else if (done && protOk) begin
            unlockCnt_ff <= unlockCnt_ff - 3'h1;
        end
    end

    // R6: Keep-running controls, protected writes only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fastKeep_ff <= RST_CONTROL[POS_KEEP_RUNNING];
            slowKeep_ff <= RST_CONTROL[POS_KEEP_RUNNING];
        end else if (wrEn && protOk) begin
            if (address[7:2] == IDX_FAST_OSC_CONTROL[5:0]) begin
                fastKeep_ff <= writedata[POS_KEEP_RUNNING];
            end else if (address[7:2] == IDX_SLOW_OSC_CONTROL[5:0]) begin
                slowKeep_ff <= writedata[POS_KEEP_RUNNING];
            end
        end
    end

    // Fuse values are caught on the first clock after reset release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fuseLoaded_ff <= 1'b0;
            calLock_ff    <= 1'b0;
        end else if (!fuseLoaded_ff) begin
            fuseLoaded_ff <= 1'b1;
            // R12: lock from fuse
            calLock_ff    <= oscLockFuseBit;
        end
    end

    // R9: R10: R11: Trim fields, fuse-loaded then locked or protected
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            freqTrim_ff <= 6'h00;
            tempTrim_ff <= 4'h0;
        end else if (!fuseLoaded_ff) begin
            freqTrim_ff <= frequencySelectFuse ? FREQ_TRIM_20M : FREQ_TRIM_16M;
            tempTrim_ff <= frequencySelectFuse ? TEMP_TRIM_20M : TEMP_TRIM_16M;
        end else if (wrEn && protOk && !calLock_ff) begin
            if (address[7:2] == IDX_FAST_OSC_FREQ[5:0]) begin
                freqTrim_ff <= writedata[FREQ_TRIM_W-1:0];
            end else if (address[7:2] == IDX_FAST_OSC_TEMP[5:0]) begin
                tempTrim_ff <= writedata[TEMP_TRIM_W-1:0];
            end
        end
    end

    // R1: External clock counted as started after its start-up edges
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            extEdges_ff   <= 2'h0;
            extStarted_ff <= 1'b0;
        end else if (!extReq) begin
            extEdges_ff   <= 2'h0;
            extStarted_ff <= 1'b0;
        end else if (oscIn.extEdge && !extStarted_ff) begin
            extEdges_ff   <= extEdges_ff + 2'h1;
            extStarted_ff <= (extEdges_ff == 2'(EXT_START_CYC - 1));
        end
    end

    // R7: R8: Fast gate counts oscillator ticks after a request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fastGateCnt_ff <= 4'h0;
            fastStable_ff  <= 1'b0;
        end else if (!fastReq) begin
            fastGateCnt_ff <= 4'h0;
            fastStable_ff  <= 1'b0;
        end else if (oscIn.fastRunning && oscIn.fastTick && !fastStable_ff) begin
            fastGateCnt_ff <= fastGateCnt_ff + 4'h1;
            fastStable_ff  <= (fastGateCnt_ff == 4'(GATE_CYCLES - 1));
        end
    end

    // R7: R8: Slow gate, same scheme
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slowGateCnt_ff <= 4'h0;
            slowStable_ff  <= 1'b0;
        end else if (!slowReq) begin
            slowGateCnt_ff <= 4'h0;
            slowStable_ff  <= 1'b0;
        end else if (oscIn.slowRunning && oscIn.slowTick && !slowStable_ff) begin
            slowGateCnt_ff <= slowGateCnt_ff + 4'h1;
            slowStable_ff  <= (slowGateCnt_ff == 4'(GATE_CYCLES - 1));
        end
    end

    // R5: Source switch waits until the new source is stable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            swState_ff   <= SW_IDLE;
            activeSrc_ff <= SRC_FAST;
        end else begin
            case (swState_ff)
                SW_IDLE: begin
                    if (mainSourceSel != activeSrc_ff) begin
                        swState_ff <= SW_WAIT;
                    end
                end
                SW_WAIT: begin
                    if (newStable) begin
                        activeSrc_ff <= mainSourceSel;
                        swState_ff   <= SW_DONE;
                    end
                end
                SW_DONE: begin
                    swState_ff <= SW_IDLE;
                end
                default: begin
                    swState_ff <= SW_IDLE;
                end
            endcase
        end
    end

    // Read data; unmapped addresses read zero with an OK response
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_ff <= 32'h0000_0000;
            resp_ff   <= 2'h0;
        end else if (access) begin
            rdData_ff <= 32'h0000_0000;
            resp_ff   <= 2'h0;
            if (read) begin
                if (address[7:2] == IDX_MAIN_CLOCK_STATUS[5:0]) begin
                    // R14: R1: R2: R3: R4: R5: status, unused bits zero
                    rdData_ff[POS_EXT_STARTED] <= extStarted_ff;
                    rdData_ff[POS_SLOW_STABLE] <= slowStable_ff & slowReq;
                    rdData_ff[POS_FAST_STABLE] <= fastStable_ff & fastReq;
                    rdData_ff[POS_SWITCH_PEND] <= (swState_ff == SW_WAIT);
                end else if (address[7:2] == IDX_FAST_OSC_CONTROL[5:0]) begin
                    rdData_ff[POS_KEEP_RUNNING] <= fastKeep_ff;
                end else if (address[7:2] == IDX_FAST_OSC_FREQ[5:0]) begin
                    rdData_ff[FREQ_TRIM_W-1:0] <= freqTrim_ff;
                end else if (address[7:2] == IDX_FAST_OSC_TEMP[5:0]) begin
                    rdData_ff[POS_CAL_LOCK]    <= calLock_ff;
                    rdData_ff[TEMP_TRIM_W-1:0] <= tempTrim_ff;
                end else if (address[7:2] == IDX_SLOW_OSC_CONTROL[5:0]) begin
                    rdData_ff[POS_KEEP_RUNNING] <= slowKeep_ff;
                end
            end
        end
    end

    // Output flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fastOscPowerOn <= 1'b0;
            slowOscPowerOn <= 1'b0;
            fastGateOpen   <= 1'b0;
            slowGateOpen   <= 1'b0;
        end else begin
            // R6: power held on by keep-running
            fastOscPowerOn <= fastKeep_ff | fastReq;
            slowOscPowerOn <= slowKeep_ff | slowReq;
            // R7: gate shut with no request
            fastGateOpen   <= fastReq & fastStable_ff;
            slowGateOpen   <= slowReq & slowStable_ff;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            waitrequest          <= 1'b1;
            activeSource         <= SRC_FAST;
            fastOscFreqTrim      <= 6'h00;
            fastOscTempSlopeTrim <= 4'h0;
        end else begin
            waitrequest          <= ~access;
            activeSource         <= activeSrc_ff;
            fastOscFreqTrim      <= freqTrim_ff;
            fastOscTempSlopeTrim <= tempTrim_ff;
        end
    end

    assign readdata = rdData_ff;
    assign response = resp_ff;

endmodule // main_clock_status_and_osc_trim

// *** verif/main_clock_status_and_osc_trim_asserts.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Port checker
// ****************************************************************
module main_clock_status_and_osc_trim_asserts
    import clk_status_pkg::*;
#(
    parameter int GATE_CYCLES = GATE_OSC_CYC
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Bus
    input wire logic        write,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // Fuse, selection and requests
    input wire logic        oscLockFuseBit,
    input wire logic [1:0]  mainSourceSel,
    input wire osc_req_type periphReq,
    input wire osc_in_type  oscIn,
    // Outputs watched
    input wire logic        fastGateOpen,
    input wire logic        slowGateOpen,
    input wire logic        slowOscPowerOn,
    input wire logic [5:0]  fastOscFreqTrim,
    input wire logic [3:0]  fastOscTempSlopeTrim
);
    logic       fastWanted;
    logic       slowWanted;
    logic [1:0] liveCnt_ff;
    logic       lockSeen_ff;
    logic [3:0] tickCnt_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Who asks for each oscillator
    assign fastWanted = periphReq.fastReq || mainSourceSel == SRC_FAST;
    assign slowWanted = periphReq.slowReq || mainSourceSel == SRC_SLOW;

    // Edges since reset; trims settle two edges after release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            liveCnt_ff  <= 2'h0;
            lockSeen_ff <= 1'b0;
        end else begin
            if (liveCnt_ff != 2'h3) begin
                liveCnt_ff <= liveCnt_ff + 2'h1;
            end
            if (liveCnt_ff == 2'h0) begin
                lockSeen_ff <= oscLockFuseBit;
            end
        end
    end

    // Slow ticks while wanted and running; saturates, so only a lower bound
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tickCnt_ff <= 4'h0;
        end else if (!(slowWanted && oscIn.slowRunning)) begin
            tickCnt_ff <= 4'h0;
        end else if (oscIn.slowTick && tickCnt_ff != 4'hF) begin
            tickCnt_ff <= tickCnt_ff + 4'h1;
        end
    end

    property p_fast_gate; !fastWanted [*2] |-> !fastGateOpen; endproperty
    a_fast_gate: assert property (p_fast_gate)
        else $error("fast gate open while unrequested");
    property p_slow_gate; !slowWanted [*2] |-> !slowGateOpen; endproperty
    a_slow_gate: assert property (p_slow_gate)
        else $error("slow gate open while unrequested");
    property p_slow_pwr; slowWanted [*2] |-> slowOscPowerOn; endproperty
    a_slow_pwr: assert property (p_slow_pwr)
        else $error("slow oscillator unpowered while requested");
    property p_slow_dly; $rose(slowGateOpen) |-> int'(tickCnt_ff) >= GATE_CYCLES; endproperty
    a_slow_dly: assert property (p_slow_dly)
        else $error("slow gate opened too early");
    property p_freq_hold; (liveCnt_ff == 2'h3 && !write) [*3] |-> $stable(fastOscFreqTrim); endproperty
    a_freq_hold: assert property (p_freq_hold)
        else $error("frequency trim moved without a write");
    property p_temp_hold; (liveCnt_ff == 2'h3 && !write) [*3] |-> $stable(fastOscTempSlopeTrim); endproperty
    a_temp_hold: assert property (p_temp_hold)
        else $error("temperature trim moved without a write");
    property p_lock; lockSeen_ff && liveCnt_ff == 2'h3 |-> $stable({fastOscFreqTrim, fastOscTempSlopeTrim}); endproperty
    a_lock: assert property (p_lock)
        else $error("trim changed while locked");
    property p_upper; !waitrequest |-> readdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper)
        else $error("upper read bits not zero");

    // Main scenarios reached
    c_slow_open: cover property ($rose(slowGateOpen));
    c_locked_write: cover property (lockSeen_ff && write && !waitrequest);
    c_read_data: cover property (!waitrequest && readdata != 32'h0);
endmodule // main_clock_status_and_osc_trim_asserts

bind main_clock_status_and_osc_trim main_clock_status_and_osc_trim_asserts #(.GATE_CYCLES(GATE_CYCLES)) chk_i (
    .clk(clk), .rst_n(rst_n), .write(write), .readdata(readdata), .waitrequest(waitrequest),
    .oscLockFuseBit(oscLockFuseBit), .mainSourceSel(mainSourceSel), .periphReq(periphReq), .oscIn(oscIn),
    .fastGateOpen(fastGateOpen), .slowGateOpen(slowGateOpen), .slowOscPowerOn(slowOscPowerOn),
    .fastOscFreqTrim(fastOscFreqTrim), .fastOscTempSlopeTrim(fastOscTempSlopeTrim));

// *** verif/main_clock_status_and_osc_trim_tb_top.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench
// ****************************************************************
module main_clock_status_and_osc_trim_tb_top;
    import clk_status_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  address = 8'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic        frequencySelectFuse = 1'b0;
    logic        oscLockFuseBit = 1'b0;
    logic [1:0]  mainSourceSel = SRC_FAST;
    osc_req_type periphReq = '0;
    osc_in_type  oscIn = '0;
    logic        extOn = 1'b0;
    logic [31:0] readdata;
    logic        waitrequest, fastOscPowerOn, slowOscPowerOn, fastGateOpen, slowGateOpen;
    logic [1:0]  activeSource, response;
    logic [5:0]  fastOscFreqTrim;
    logic [3:0]  fastOscTempSlopeTrim;
    logic [2:0]  flags;
    logic [31:0] seed = 32'h0000F719;
    logic [7:0]  expQ[$];
    int          miscompares = 0;
    int          totalChecks = 0;

    main_clock_status_and_osc_trim #(.FREQ_TRIM_16M(6'h2A), .FREQ_TRIM_20M(6'h33), .TEMP_TRIM_16M(4'h5),
        .TEMP_TRIM_20M(4'hC)) main_clock_status_and_osc_trim_i (.clk(clk), .rst_n(rst_n), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
        .waitrequest(waitrequest), .response(response), .frequencySelectFuse(frequencySelectFuse),
        .oscLockFuseBit(oscLockFuseBit), .mainSourceSel(mainSourceSel), .periphReq(periphReq), .oscIn(oscIn),
        .fastOscPowerOn(fastOscPowerOn), .slowOscPowerOn(slowOscPowerOn), .fastGateOpen(fastGateOpen),
        .slowGateOpen(slowGateOpen), .activeSource(activeSource), .fastOscFreqTrim(fastOscFreqTrim),
        .fastOscTempSlopeTrim(fastOscTempSlopeTrim));

    // Clock, and the conditions a bounded wait can stop on
    always #4 clk = ~clk;
    assign flags = {activeSource == SRC_EXT, fastGateOpen, slowGateOpen};

    // Oscillator ticks every second cycle, only while running
    always @(posedge clk) begin
        oscIn.fastTick <= oscIn.fastRunning & ~oscIn.fastTick;
        oscIn.slowTick <= oscIn.slowRunning & ~oscIn.slowTick;
        oscIn.extEdge  <= extOn & ~oscIn.extEdge;
    end

    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    // One bus access; for a read, val is the expected byte
    task automatic access(input logic [7:0] idx, input logic wr, input logic [7:0] val);
        int n;
        @(posedge clk);
        n = 0;
        address   <= {idx[5:0], 2'h0};
        read      <= ~wr;
        write     <= wr;
        writedata <= {24'h0, val};
        if (!wr) expQ.push_back(val);
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 40);
        read  <= 1'b0;
        write <= 1'b0;
        if (waitrequest !== 1'b0) begin
            miscompares++;
            report_and_stop();
        end
    endtask

    task automatic keyed(input logic [7:0] idx, input logic [7:0] val);
        access(IDX_PROTECT_KEY, 1'b1, PROTECT_KEY);
        access(idx, 1'b1, val);
    endtask

    // Bounded wait for one of the flags
    task automatic waitUntil(input int what);
        int n;
        n = 0;
        while (flags[what] !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        if (flags[what] !== 1'b1) begin
            miscompares++;
            report_and_stop();
        end
    endtask

    // Read answers are matched against the oldest expectation
    always @(posedge clk) begin
        if (read && waitrequest === 1'b0) begin
            chk(readdata, {24'h0, expQ.pop_front()});
            chk(32'(response), 32'h0);
        end
    end

    // Main sequence
    initial begin
        logic [7:0] val;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        access(IDX_MAIN_CLOCK_STATUS, 1'b0, 8'h00);
        access(IDX_SLOW_OSC_CONTROL, 1'b0, RST_CONTROL);
        access(IDX_FAST_OSC_FREQ, 1'b0, 8'h2A);
        access(IDX_FAST_OSC_TEMP, 1'b0, 8'h05);
        chk(32'(slowOscPowerOn), 32'h0);
        chk(32'(fastOscPowerOn), 32'h1);
        access(IDX_SLOW_OSC_CONTROL, 1'b1, 8'h02);
        access(IDX_SLOW_OSC_CONTROL, 1'b0, 8'h00);
        // Key window: last allowed access, then one past it
        access(IDX_PROTECT_KEY, 1'b1, PROTECT_KEY);
        repeat (UNLOCK_WINDOW - 1) access(8'h01, 1'b0, 8'h00);
        access(IDX_SLOW_OSC_CONTROL, 1'b1, 8'h02);
        access(IDX_PROTECT_KEY, 1'b1, PROTECT_KEY);
        repeat (UNLOCK_WINDOW) access(8'h01, 1'b0, 8'h00);
        access(IDX_FAST_OSC_CONTROL, 1'b1, 8'h02);
        access(IDX_FAST_OSC_CONTROL, 1'b0, 8'h00);
        access(IDX_SLOW_OSC_CONTROL, 1'b0, 8'h02);
        chk(32'(slowOscPowerOn), 32'h1);
        // Kept running but unrequested slow oscillator
        oscIn.fastRunning <= 1'b1;
        oscIn.slowRunning <= 1'b1;
        waitUntil(1);
        access(IDX_MAIN_CLOCK_STATUS, 1'b0, 8'h10);
        chk(32'(slowGateOpen), 32'h0);
        periphReq.slowReq <= 1'b1;
        waitUntil(0);
        access(IDX_MAIN_CLOCK_STATUS, 1'b0, 8'h30);
        periphReq.slowReq <= 1'b0;
        access(IDX_MAIN_CLOCK_STATUS, 1'b0, 8'h10);
        chk(32'(slowGateOpen), 32'h0);
        // Random trims, the lock bit staying read-only
        repeat (3) begin
            val = rnd();
            keyed(IDX_FAST_OSC_FREQ, val);
            keyed(IDX_FAST_OSC_TEMP, val);
            access(IDX_FAST_OSC_FREQ, 1'b0, {2'h0, val[5:0]});
            access(IDX_FAST_OSC_TEMP, 1'b0, {4'h0, val[3:0]});
            chk(32'(fastOscFreqTrim), 32'(val[5:0]));
        end
        keyed(IDX_MAIN_CLOCK_STATUS, 8'hFF);
        access(IDX_MAIN_CLOCK_STATUS, 1'b0, 8'h10);
        // Switch to the external clock
        periphReq <= 3'b101;
        mainSourceSel <= SRC_EXT;
        access(IDX_MAIN_CLOCK_STATUS, 1'b0, 8'h11);
        extOn <= 1'b1;
        waitUntil(2);
        periphReq.fastReq <= 1'b0;
        access(IDX_MAIN_CLOCK_STATUS, 1'b0, 8'h80);
        // Second reset with the lock fuse set
        mainSourceSel <= SRC_FAST;
        periphReq <= '0;
        extOn <= 1'b0;
        oscLockFuseBit <= 1'b1;
        frequencySelectFuse <= 1'b1;
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        keyed(IDX_FAST_OSC_FREQ, 8'h15);
        keyed(IDX_FAST_OSC_TEMP, 8'h0A);
        access(IDX_FAST_OSC_FREQ, 1'b0, 8'h33);
        access(IDX_FAST_OSC_TEMP, 1'b0, 8'h8C);
        chk(32'(fastOscTempSlopeTrim), 32'hC);
        report_and_stop();
    end
endmodule // main_clock_status_and_osc_trim_tb_top
